// *** core/dramt_map.svh ***
// Register offsets, field positions and reset values of the DRAM access timing block
`ifndef DRAMT_MAP_SVH
`define DRAMT_MAP_SVH

// -----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// -----------------------------------------------------------------
`define DRAMT_OFS_TIMING 4'h0
`define DRAMT_OFS_STATUS 4'h4

// -----------------------------------------------------------------
// Field low-bit positions inside the timing register
// -----------------------------------------------------------------
`define DRAMT_LAST_WRITE_TO_STROBE_LSB 13
`define DRAMT_ROW_STROBE_WIDTH_LSB 11
`define DRAMT_COLUMN_ADDRESS_HOLD_BIT 10
`define DRAMT_READ_STROBE_WIDTH_LSB 8
`define DRAMT_WRITE_STROBE_WIDTH_LSB 6
`define DRAMT_COLUMN_PRECHARGE_BIT 5
`define DRAMT_ROW_TO_COLUMN_DELAY_LSB 2

// -----------------------------------------------------------------
// Reset value and writable bits of the timing register
// -----------------------------------------------------------------
// Strobe setup code 01, row width 10, hold 1, read 01, write 00, precharge 0, delay 10
`define DRAMT_TIMING_RESET 32'h0000_3508
`define DRAMT_TIMING_MASK 32'h0000_7fec

// -----------------------------------------------------------------
// Cycle offsets of the field codes
// -----------------------------------------------------------------
`define DRAMT_ROW_STROBE_BASE 5'h04
`define DRAMT_READ_STROBE_BASE 5'h02
`define DRAMT_WRITE_STROBE_BASE 5'h02
`define DRAMT_WRITE_STROBE_MAX 5'h04
`define DRAMT_ROW_TO_COLUMN_BASE 5'h02
`define DRAMT_LAST_WRITE_MIN 5'h02

`endif

// *** core/dramt_pkg.sv ***
// Types shared by the DRAM access timing block
package dramt_pkg;

  // -----------------------------------------------------------------
  // Sequencer states and cycle counts
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    dramt_st_idle = 2'b01,
    dramt_st_active = 2'b10
  } dramt_state_t;

  typedef logic [4:0] dramt_cnt_t;

endpackage

// *** core/dramt_decode.sv ***
// Decoder from timing register fields to cycle counts
`timescale 1ns/1ps
`default_nettype none
`include "dramt_map.svh"

module dramt_decode import dramt_pkg::*; (
  // Timing register word
  input wire logic [31:0] timing,
  // Decoded cycle counts
  output dramt_cnt_t setup,
  output dramt_cnt_t row_width,
  output dramt_cnt_t col_hold,
  output dramt_cnt_t read_width,
  output dramt_cnt_t write_width,
  output dramt_cnt_t write_hold,
  output dramt_cnt_t col_prech,
  output dramt_cnt_t row_to_col
);

  // Two-bit code plus a base count
  function automatic dramt_cnt_t code_plus(input logic [1:0] code, input dramt_cnt_t base);
    return {3'h0, code} + base;
  endfunction

  dramt_cnt_t last_write;

  // Reserved code 00 behaves like the smallest legal setting
  assign last_write = (timing[`DRAMT_LAST_WRITE_TO_STROBE_LSB +: 2] == 2'h0) ? `DRAMT_LAST_WRITE_MIN :
                      code_plus(timing[`DRAMT_LAST_WRITE_TO_STROBE_LSB +: 2], 5'h01);
  assign setup = last_write - 5'h01;

  // Strobe widths
  assign row_width = code_plus(timing[`DRAMT_ROW_STROBE_WIDTH_LSB +: 2], `DRAMT_ROW_STROBE_BASE);
  assign read_width = code_plus(timing[`DRAMT_READ_STROBE_WIDTH_LSB +: 2], `DRAMT_READ_STROBE_BASE);
  // Reserved code 11 is clamped to the widest legal strobe
  assign write_width = (timing[`DRAMT_WRITE_STROBE_WIDTH_LSB +: 2] == 2'h3) ? `DRAMT_WRITE_STROBE_MAX :
                       code_plus(timing[`DRAMT_WRITE_STROBE_WIDTH_LSB +: 2], `DRAMT_WRITE_STROBE_BASE);
  assign write_hold = (write_width == 5'h02) ? 5'h01 : 5'h02;

  // Single-bit selections and the two-bit row-to-column delay
  assign col_hold = timing[`DRAMT_COLUMN_ADDRESS_HOLD_BIT] ? 5'h02 : 5'h01;
  assign col_prech = timing[`DRAMT_COLUMN_PRECHARGE_BIT] ? 5'h02 : 5'h01;
  assign row_to_col = code_plus(timing[`DRAMT_ROW_TO_COLUMN_DELAY_LSB +: 2], `DRAMT_ROW_TO_COLUMN_BASE);

endmodule
`default_nettype wire

// *** core/dramt_timing_ctrl.sv ***
// DRAM access sequencer with programmable strobe timing and Avalon-MM registers
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dramt_map.svh"

// Behaviour
// - Write data is driven last-write-to-strobe minus one cycles before column strobe.
// - Write data held one cycle after strobe for width two, else two.
// - Row strobe stays asserted at least 4 to 7 cycles, default six.
// - Column address held one or two cycles after strobe, default two.
// - Read column strobe lasts 2 to 5 cycles, default three.
// - Write column strobe lasts two cycles at code 00, four at 10.
// - Last-write-to-strobe codes 01, 10, 11 give 2, 3, 4 cycles.
// - Column strobe precharge is one cycle when clear, two when set.
module dramt_timing_ctrl import dramt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Access request port
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [11:0] acc_row,
  input wire logic [11:0] acc_col,
  input wire logic [31:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic [31:0] acc_rdata,
  // DRAM array pins
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic [11:0] mem_addr,
  output logic [31:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [31:0] mem_dq_in
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic [31:0] timing;
  logic [31:0] status;
  logic [31:0] wr_mask;
  dramt_cnt_t dec_setup, dec_rasp, dec_addr_hold, dec_read_width, dec_write_width, dec_hold, dec_prech, dec_delay;
  dramt_state_t state, next_state;
  dramt_cnt_t t, next_t;
  logic lat_write;
  logic [11:0] lat_row, lat_col;
  logic [31:0] lat_wdata;
  dramt_cnt_t lat_setup, lat_rasp, lat_addr_hold, lat_width, lat_hold, lat_prech, lat_delay;
  dramt_cnt_t lead, t_ras, t_cas, t_cas_end, t_ras_end, t_end, t_dq_start, t_dq_end, t_col_end;
  logic start, finishing, in_act;
  logic next_ras_n, next_cas_n, next_dq_oe;
  logic [11:0] next_addr;

  // Larger of two cycle counts
  function automatic dramt_cnt_t max_cnt(input dramt_cnt_t a, input dramt_cnt_t b);
    return (a > b) ? a : b;
  endfunction

  // -----------------------------------------------------------------
  // Field decoding
  // -----------------------------------------------------------------
  dramt_decode u_dramt_decode (
    .timing(timing),
    .setup(dec_setup),
    .row_width(dec_rasp),
    .col_hold(dec_addr_hold),
    .read_width(dec_read_width),
    .write_width(dec_write_width),
    .write_hold(dec_hold),
    .col_prech(dec_prech),
    .row_to_col(dec_delay)
  );

  // -----------------------------------------------------------------
  // Register slave
  // -----------------------------------------------------------------
  // Byte lanes gate the writable field bits
  assign wr_mask = `DRAMT_TIMING_MASK & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign status = {19'h0, t, 6'h0, lat_write, (state == dramt_st_active)};

  // One wait state per access; the answer is registered so the bus sees no combinational path
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      if (avs_read && avs_address == `DRAMT_OFS_TIMING) begin
        avs_readdata <= timing;
      end else if (avs_read && avs_address == `DRAMT_OFS_STATUS) begin
        avs_readdata <= status;
      end else begin
        avs_readdata <= 32'h0;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Timing register; a change applies from the next accepted access
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timing <= `DRAMT_TIMING_RESET;
    end else if (avs_write && !avs_waitrequest && avs_address == `DRAMT_OFS_TIMING) begin
      timing <= (timing & ~wr_mask) | (avs_writedata & wr_mask);
    end
  end

  // -----------------------------------------------------------------
  // Access latch
  // -----------------------------------------------------------------
  assign start = (state == dramt_st_idle) && acc_req && acc_ready;

  // Counts are frozen per access so a register write mid-access cannot tear a strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lat_write <= 1'b0;
      lat_row <= 12'h0;
      lat_col <= 12'h0;
      lat_wdata <= 32'h0;
      lat_setup <= 5'h01;
      lat_rasp <= 5'h06;
      lat_addr_hold <= 5'h02;
      lat_width <= 5'h03;
      lat_hold <= 5'h01;
      lat_prech <= 5'h01;
      lat_delay <= 5'h04;
    end else if (start) begin
      lat_write <= acc_write;
      lat_row <= acc_row;
      lat_col <= acc_col;
      lat_wdata <= acc_wdata;
      lat_setup <= dec_setup;
      lat_rasp <= dec_rasp;
      lat_addr_hold <= dec_addr_hold;
      lat_width <= acc_write ? dec_write_width : dec_read_width;
      lat_hold <= dec_hold;
      lat_prech <= dec_prech;
      lat_delay <= dec_delay;
    end
  end

  // -----------------------------------------------------------------
  // Access schedule, in cycles from acceptance
  // -----------------------------------------------------------------
  // Lead cycle before the row strobe when the data setup exceeds the row-to-column delay
  assign lead = (lat_setup > lat_delay) ? (lat_setup - lat_delay) : 5'h00;
  assign t_ras = lead + 5'h01;
  assign t_cas = t_ras + lat_delay;
  assign t_cas_end = t_cas + lat_width;
  assign t_ras_end = max_cnt(t_ras + lat_rasp, t_cas_end);
  assign t_end = max_cnt(t_ras_end, t_cas_end + lat_prech);
  assign t_dq_start = t_cas - lat_setup;
  assign t_dq_end = t_cas + lat_hold;
  assign t_col_end = t_cas + lat_addr_hold;

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  // Next state and cycle position
  always_comb begin
    next_state = state;
    next_t = t;
    case (state)
      dramt_st_idle: begin
        if (start) begin
          next_state = dramt_st_active;
          next_t = 5'h00;
        end
      end
      dramt_st_active: begin
        if (t + 5'h01 >= t_end) begin
          next_state = dramt_st_idle;
          next_t = 5'h00;
        end else begin
          next_t = t + 5'h01;
        end
      end
      default: begin
        next_state = dramt_st_idle;
        next_t = 5'h00;
      end
    endcase
  end

  assign finishing = (state == dramt_st_active) && (next_state == dramt_st_idle);

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= dramt_st_idle;
      t <= 5'h00;
    end else begin
      state <= next_state;
      t <= next_t;
    end
  end

  // -----------------------------------------------------------------
  // Pin values for the next cycle
  // -----------------------------------------------------------------
  // Cycle 0 of an access is neutral, so stale counts at the acceptance edge do no harm
  always_comb begin
    in_act = (next_state == dramt_st_active);
    next_ras_n = !(in_act && next_t >= t_ras && next_t < t_ras_end);
    next_cas_n = !(in_act && next_t >= t_cas && next_t < t_cas_end);
    next_dq_oe = in_act && lat_write && next_t >= t_dq_start && next_t < t_dq_end;
    if (in_act && next_t >= t_cas - 5'h01 && next_t < t_col_end) begin
      next_addr = lat_col;
    end else if (in_act && next_t >= t_ras && next_t < t_cas - 5'h01) begin
      next_addr = lat_row;
    end else begin
      next_addr = 12'h0;
    end
  end

  // Pins straight from flip-flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_ras_n <= 1'b1;
      mem_cas_n <= 1'b1;
      mem_addr <= 12'h0;
      mem_dq_oe <= 1'b0;
      mem_dq_out <= 32'h0;
    end else begin
      mem_ras_n <= next_ras_n;
      mem_cas_n <= next_cas_n;
      mem_addr <= next_addr;
      mem_dq_oe <= next_dq_oe;
      mem_dq_out <= next_dq_oe ? lat_wdata : 32'h0;
    end
  end

  // -----------------------------------------------------------------
  // Request port handshake and read capture
  // -----------------------------------------------------------------
  // Read data sampled in the last strobe cycle, giving the full width as setup
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_rdata <= 32'h0;
    end else if (state == dramt_st_active && !lat_write && t == t_cas_end - 5'h01) begin
      acc_rdata <= mem_dq_in;
    end
  end

  // Ready and completion
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_ready <= 1'b1;
      acc_done <= 1'b0;
    end else begin
      acc_ready <= (next_state == dramt_st_idle);
      acc_done <= finishing;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  dramt_cnt_t ras_run, cas_run, oe_run;

  // Saturating run lengths of the strobes and the data drive
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ras_run <= 5'h00;
      cas_run <= 5'h00;
      oe_run <= 5'h00;
    end else begin
      ras_run <= next_ras_n ? 5'h00 : ((ras_run == 5'h1f) ? ras_run : ras_run + 5'h01);
      cas_run <= next_cas_n ? 5'h00 : ((cas_run == 5'h1f) ? cas_run : cas_run + 5'h01);
      oe_run <= !next_dq_oe ? 5'h00 : ((oe_run == 5'h1f) ? oe_run : oe_run + 5'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_col_held;
    (mem_addr == lat_col) ##1 ((lat_addr_hold == 5'h01) || (mem_addr == lat_col));
  endsequence

  // Completion may not cut the precharge short, else the next strobe could follow too soon
  sequence s_cas_prech;
    (mem_cas_n && !acc_done) ##1 ((lat_prech == 5'h01) || (mem_cas_n && !acc_done));
  endsequence

  a_data_setup: assert property (($fell(mem_cas_n) && lat_write) |-> ($past(oe_run) == lat_setup))
    else $error("write data setup before column strobe is wrong");
  a_data_hold: assert property ($fell(mem_dq_oe) |-> ($past(cas_run) == lat_hold))
    else $error("write data hold after column strobe is wrong");
  a_ras_width: assert property ($rose(mem_ras_n) |-> ($past(ras_run) >= lat_rasp))
    else $error("row strobe shorter than programmed");
  a_col_hold: assert property ($fell(mem_cas_n) |-> s_col_held)
    else $error("column address changed too early");
  a_read_width: assert property (($rose(mem_cas_n) && !lat_write) |-> ($past(cas_run) == lat_width))
    else $error("read strobe width wrong");
  a_write_width: assert property (($rose(mem_cas_n) && lat_write) |-> ($past(cas_run) == lat_width))
    else $error("write strobe width wrong");
  a_write_decode: assert property ((timing[7:6] == 2'h1) |-> (dec_write_width == 5'h03))
    else $error("write strobe code 01 not three cycles");
  a_setup_decode: assert property ((timing[14:13] != 2'h0) |-> (dec_setup == 5'(timing[14:13])))
    else $error("last write to strobe decode wrong");
  a_cas_prech: assert property ($rose(mem_cas_n) |-> s_cas_prech)
    else $error("column strobe precharge too short");
  a_reset_value: assert property (!$past(resetn) |-> (timing == `DRAMT_TIMING_RESET))
    else $error("timing register reset value wrong");
  a_done_idle: assert property (acc_done |-> (acc_ready && mem_ras_n && mem_cas_n && !mem_dq_oe))
    else $error("completion while pins still active");

endmodule
`default_nettype wire

// *** sim/dramt_mem_model.sv ***
// Behavioural DRAM array that answers the timing block's strobes
`timescale 1ns/1ps
`default_nettype none

module dramt_mem_model (
  // Clock
  input wire logic clk,
  // Strobes and address
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic [11:0] mem_addr,
  // Data lanes
  input wire logic [31:0] mem_dq_out,
  input wire logic mem_dq_oe,
  output logic [31:0] mem_dq_in
);
  logic [31:0] store [logic [23:0]];
  logic [11:0] row;
  logic ras_q;
  logic cas_q;

  initial begin
    mem_dq_in = 32'h5a5a_a5a5;
    row = 12'h000;
    ras_q = 1'b1;
    cas_q = 1'b1;
  end

  // -----------------------------------------------------------------
  // Array access
  // -----------------------------------------------------------------
  // Sampled mid-cycle, where the registered pins have settled
  always @(negedge clk) begin
    ras_q <= mem_ras_n;
    cas_q <= mem_cas_n;
    if (!mem_ras_n && ras_q) begin
      row <= mem_addr;
    end
    if (!mem_cas_n && cas_q) begin
      if (mem_dq_oe) begin
        store[{row, mem_addr}] = mem_dq_out;
      end
      mem_dq_in <= store.exists({row, mem_addr}) ? store[{row, mem_addr}] : ~mem_dq_in;
    end else if (mem_cas_n) begin
      // Undriven bus toggles so stale data never passes as a read
      mem_dq_in <= ~mem_dq_in;
    end
  end
endmodule
`default_nettype wire

// *** sim/test_dramt_timing_ctrl.sv ***
// Self-checking testbench of the DRAM access timing block
`timescale 1ns/1ps
`default_nettype none
`include "dramt_map.svh"

module test_dramt_timing_ctrl;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic acc_req, acc_write, acc_ready, acc_done, mem_ras_n, mem_cas_n, mem_dq_oe;
  logic [11:0] acc_row, acc_col, mem_addr;
  logic [31:0] acc_wdata, acc_rdata, mem_dq_out, mem_dq_in;
  int err_total = 0;
  int check_count = 0;
  int e_last_write = 2, e_rasp = 6, e_addr_hold = 2, e_read_width = 3, e_write_width = 2, e_prech = 1;
  localparam int row_to_col = 4;
  localparam logic [4:0] wtab [7] = '{5'h02, 5'h05, 5'h0b, 5'h0d, 5'h12, 5'h14, 5'h17};

  // -----------------------------------------------------------------
  // Design and DRAM model
  // -----------------------------------------------------------------
  dramt_timing_ctrl u_dramt_timing_ctrl (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc_req(acc_req), .acc_write(acc_write), .acc_row(acc_row), .acc_col(acc_col),
    .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
  dramt_mem_model u_dramt_mem_model (.clk(clk), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Program every field except the row-to-column delay (kept at code 10), read back, and note the cycle counts it selects
  task automatic cfg(input logic [1:0] last_wr, input logic [1:0] rasp, input logic addr_hold,
                     input logic [1:0] rd_w, input logic [1:0] wr_w, input logic prech);
    logic [31:0] w;
    logic [31:0] q;
    w = {17'h0, last_wr, rasp, addr_hold, rd_w, wr_w, prech, 5'h08};
    bus(1'b1, `DRAMT_OFS_TIMING, w, 4'hf, q);
    bus(1'b0, `DRAMT_OFS_TIMING, 32'h0, 4'hf, q);
    check(q, w);
    e_last_write = last_wr + 1;
    e_rasp = rasp + 4;
    e_addr_hold = addr_hold + 1;
    e_read_width = rd_w + 2;
    e_write_width = wr_w + 2;
    e_prech = prech + 1;
  endtask

  // One access; pins measured mid-cycle from accept to completion
  task automatic access(input logic wr, input logic [11:0] row, input logic [11:0] col,
                        input logic [31:0] d, input logic [31:0] exp_rd);
    int n, w, pre_exp;
    int ras = 0, cas = 0, hold = 0, pre = 0, opre = 0, opost = 0, bad = 0, rowc = 0, busy = 0;
    logic seen = 1'b0;
    w = wr ? e_write_width : e_read_width;
    pre_exp = imax(e_rasp - row_to_col - w, e_prech);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_row <= row;
    acc_col <= col;
    acc_wdata <= d;
    @(posedge clk);
    acc_req <= 1'b0;
    for (n = 0; n < 80; n++) begin
      @(negedge clk);
      if (acc_done === 1'b1) break;
      if (acc_ready === 1'b0) busy++;
      if (mem_ras_n === 1'b0) ras++;
      // Row address stands on the pins until the column takes over
      if (mem_ras_n === 1'b0 && !seen && mem_addr === row) rowc++;
      if (mem_cas_n === 1'b0) begin
        cas++;
        seen = 1'b1;
        if (mem_addr === col) hold++;
      end else if (seen) begin
        pre++;
      end
      if (mem_dq_oe === 1'b1) begin
        if (mem_cas_n === 1'b1) opre++;
        else opost++;
        if (mem_dq_out !== d) bad++;
      end
    end
    if (n == 80) err_total++;
    check(cas, w);
    check(ras, imax(e_rasp, row_to_col + w));
    check(hold, e_addr_hold);
    check(rowc, row_to_col - 1);
    check(pre, pre_exp);
    check(busy, 1 + row_to_col + w + pre_exp);
    check(acc_ready, 1'b1);
    check(opre, wr ? e_last_write - 1 : 0);
    check(opost, wr ? ((w == 2) ? 1 : 2) : 0);
    check(bad, 0);
    if (!wr) check(acc_rdata, exp_rd);
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    bus(1'b0, `DRAMT_OFS_TIMING, 32'h0, 4'hf, q);
    check(q, 32'h0000_3508);
    bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, 4'h8, 32'h0, 4'hf, q);
    check(q, 32'h0);
    bus(1'b1, `DRAMT_OFS_TIMING, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, `DRAMT_OFS_TIMING, 32'h0, 4'hf, q);
    check(q, 32'h0000_7fec);
    // Only lane 1 written: fields above bit 7 clear, the rest stay
    bus(1'b1, `DRAMT_OFS_TIMING, 32'h0, 4'h2, q);
    bus(1'b0, `DRAMT_OFS_TIMING, 32'h0, 4'hf, q);
    check(q, 32'h0000_00ec);
    bus(1'b1, `DRAMT_OFS_TIMING, 32'h0000_3508, 4'hf, q);
    bus(1'b0, `DRAMT_OFS_STATUS, 32'h0, 4'hf, q);
    check(q[0], 1'b0);
    $display("test registers done");
  endtask

  // Reset timing: read strobe three cycles, write two, hold two
  task automatic t_default;
    access(1'b1, 12'h012, 12'h345, 32'hc0de_0001, 32'h0);
    access(1'b0, 12'h012, 12'h345, 32'h0, 32'hc0de_0001);
    $display("test reset timing done");
  endtask

  // Every read width and row width code, both hold and precharge values
  task automatic t_read_sweep;
    for (int i = 0; i < 4; i++) begin
      cfg(2'b01, 2'(3 - i), (i >= 2), 2'(i), 2'b00, i[0]);
      access(1'b0, 12'h012, 12'h345, 32'h0, 32'hc0de_0001);
    end
    $display("test read widths done");
  endtask

  // Seven write width, setup and precharge combinations, covering each legal value of these three fields
  task automatic t_write_sweep;
    logic [1:0] rw_code;
    for (int i = 0; i < 7; i++) begin
      // Four-cycle strobes need the seven-cycle row width to keep the row sums legal
      rw_code = (wtab[i][4:3] == 2'b10) ? 2'b11 : 2'b10;
      cfg(wtab[i][2:1], rw_code, 1'b0, wtab[i][4:3], wtab[i][4:3], wtab[i][0]);
      access(1'b1, 12'(12'h100 + i), 12'(12'h020 + i), 32'h1234_0000 + i, 32'h0);
      access(1'b0, 12'(12'h100 + i), 12'(12'h020 + i), 32'h0, 32'h1234_0000 + i);
    end
    $display("test write combinations done");
  endtask

  // -----------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_row = 12'h000;
    acc_col = 12'h000;
    acc_wdata = 32'h0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_default;
    t_read_sweep;
    t_write_sweep;
    complete_run;
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    $display("watchdog expired");
    err_total++;
    complete_run;
  end
endmodule
`default_nettype wire
